// ===== shared/gfx_regs_pkg.sv
package gfx_regs_pkg;

  // register addresses in the i/o space
  localparam logic [15:0] SUBSYS_ADDR      = 16'h42e8;
  localparam logic [15:0] DISP_FUNC_ADDR   = 16'h4ae8;
  localparam logic [15:0] ROW_START_ADDR   = 16'h82e8;
  localparam logic [15:0] ROW_START2_ADDR  = 16'h82ea;
  localparam logic [15:0] CRTC_INDEX_ADDR  = 16'h03d4;
  localparam logic [15:0] CRTC_DATA_ADDR   = 16'h03d5;
  localparam logic [7:0]  SCRATCH_INDEX    = 8'h6c;

  // reset values
  localparam logic [15:0] STATUS_RESET     = 16'h0000;
  localparam logic [15:0] CONTROL_RESET    = 16'h0000;
  localparam logic [15:0] DISP_FUNC_RESET  = 16'h0000;
  localparam logic [7:0]  SCRATCH_RESET    = 8'h00;

  // field positions
  localparam int FLAG_VSYNC      = 0;
  localparam int FLAG_BUSY       = 1;
  localparam int FLAG_OVERFLOW   = 2;
  localparam int FLAG_EMPTY      = 3;
  localparam int NUM_FLAGS       = 4;
  localparam int CLEAR_LSB       = 0;
  localparam int ENABLE_LSB      = 8;
  localparam int ENG_RST_LSB     = 14;
  localparam int PLANE_DEPTH_BIT = 7;
  localparam int ENH_SELECT_BIT  = 0;
  localparam int ENH_PIXEL_BIT   = 2;
  localparam int LINEAR_BIT      = 4;
  localparam int MMIO_BIT        = 5;
  localparam int ROW_WIDTH       = 12;
  localparam logic [15:0] DISP_FUNC_MASK = 16'h0035;

  typedef enum logic [1:0] {
    ENG_NO_CHANGE = 2'b00,
    ENG_ENABLE    = 2'b01,
    ENG_RESET     = 2'b10,
    ENG_RESERVED  = 2'b11
  } eng_rst_code_t;

  // one i/o access from the host
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } io_req_t;

  // sources raising the four events
  typedef struct packed {
    logic empty;
    logic overflow;
    logic busy;
    logic vsync;
  } irq_events_t;

endpackage

// ===== design/scratch_store.sv
`timescale 1ns/10ps
module scratch_store
  import gfx_regs_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_in,   // clock
  input  wire logic             rstn_in,  // synced reset, active low
  input  wire logic             we_in,    // write strobe
  input  wire logic [WIDTH-1:0] wdata_in, // write data
  output logic      [WIDTH-1:0] rdata_out // registered contents
);

  // width the reset constant cannot serve
  if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
    $error("scratch_store: WIDTH must be 1..8");
  end

  // firmware storage only, no hardware effect
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= SCRATCH_RESET[WIDTH-1:0];
    end else if (we_in) begin
      rdata_out <= wdata_in;
    end
  end

endmodule

// ===== design/graphics_engine_control_regs.sv
`timescale 1ns/10ps
// Summary of operation
// R1: enhanced register set reachable only while system configuration bit 0 set
// R2: reserved bits written as zero; reads return zero here
// R3: status word flags vsync, busy, overflow, empty at bits 0-3; reset zero
// R4: status bit 7 reports plane depth: 0 four-bit, 1 eight-bit
// R5: shared address: read gives status, write updates control word
// R6: control bits 0-3 written one clear matching status flags
// R7: control bits 8-11 enable the four interrupts
// R8: engine reset field: 00 hold, 01 enable, 10 reset, 11 reserved
// R9: display function bit 0 selects enhanced non-planar modes
// R10: display function bit 2 selects four-bit enhanced pixel length
// R11: linear addressing is display bit 4 OR linear window control bit 4
// R12: memory mapped access is display bit 5 OR memory control bit 4
// R13: display function control read/write, zero after reset
// R14: first row register sets 12-bit start row; read returns current row
// R15: first row also gives blit corner row and first polygon edge row
// R16: second row register holds second edge start row; read current row
// R17: indexed 8-bit scratch byte, reset zero, no hardware effect
// R18: interrupt output high while any flag set with its enable
// R19: reset code holds engine and queue in reset until enable code
module graphics_engine_control_regs
  import gfx_regs_pkg::*;
(
  input  wire logic        clk_in,            // 10 MHz clock
  input  wire logic        rstn_in,           // async reset, active low
  input  wire io_req_t     io_req_in,         // host i/o access
  output logic      [15:0] io_rdata_out,      // read data, registered
  input  wire logic        sys_config_in,     // system configuration bit 0
  input  wire logic        ext_sys_depth_in,  // extended system control pixel field is 00b
  input  wire logic        plane_8bit_in,     // bit-plane count is eight
  input  wire logic        linear_ctl_in,     // linear window control bit 4
  input  wire logic        mem_ctl_in,        // extended memory control bit 4
  input  wire irq_events_t events_in,         // one-cycle event pulses
  input  wire logic        row_update_in,     // engine writes back current row
  input  wire logic [11:0] row_cur_in,        // engine current row
  input  wire logic        row2_update_in,    // engine writes back second-edge row
  input  wire logic [11:0] row2_cur_in,       // engine second-edge row
  output logic             irq_out,           // interrupt request, active high
  output logic             engine_rstn_out,   // engine and queue reset, active low
  output logic             enhanced_mode_out, // enhanced non-planar modes
  output logic             pixel_4bit_out,    // four-bit enhanced pixel length
  output logic             linear_window_out, // effective linear addressing
  output logic             mmio_out,          // effective memory mapped access
  output logic      [11:0] row_start_out,     // first edge start row
  output logic      [11:0] row_start2_out     // second edge start row
);

  logic        rst_meta;
  logic        rst_sync_n;
  logic [NUM_FLAGS-1:0] status_flags;
  logic [NUM_FLAGS-1:0] irq_enables;
  logic        engine_held;
  logic [15:0] disp_func;
  logic [11:0] row_start;
  logic [11:0] row_start2;
  logic [7:0]  crtc_index;
  logic [7:0]  scratch_q;
  logic [NUM_FLAGS-1:0] next_status;

  // reset release through two flops
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // field layout below is fixed to four sources and 12-bit rows
  if (NUM_FLAGS != 4) begin : g_bad_flags
    $error("graphics_engine_control_regs: four interrupt sources expected");
  end
  if (ROW_WIDTH != 12) begin : g_bad_row
    $error("graphics_engine_control_regs: row width must be 12");
  end

  function automatic logic hit(input io_req_t r, input logic [15:0] a);
    return r.addr == a;
  endfunction

  // host load wins over engine write-back
  function automatic logic [ROW_WIDTH-1:0] pick_row(
    input logic                 host_wr,
    input logic [15:0]          host_data,
    input logic                 eng_wr,
    input logic [ROW_WIDTH-1:0] eng_row,
    input logic [ROW_WIDTH-1:0] held_row
  );
    if (host_wr) begin
      return host_data[ROW_WIDTH-1:0];
    end else if (eng_wr) begin
      return eng_row;
    end
    return held_row;
  endfunction

  // R1: gate enhanced set
  wire enh_access  = sys_config_in;
  wire sel_ctl     = enh_access & hit(io_req_in, SUBSYS_ADDR);
  wire sel_disp    = enh_access & hit(io_req_in, DISP_FUNC_ADDR);
  wire sel_row     = enh_access & hit(io_req_in, ROW_START_ADDR);
  wire sel_row2    = enh_access & hit(io_req_in, ROW_START2_ADDR);
  // index and data ports stay open in every mode
  wire sel_index   = hit(io_req_in, CRTC_INDEX_ADDR);
  wire sel_scratch = hit(io_req_in, CRTC_DATA_ADDR) & (crtc_index == SCRATCH_INDEX);
  wire wr_ctl      = io_req_in.wr & sel_ctl;
  wire wr_disp     = io_req_in.wr & sel_disp;
  wire wr_row      = io_req_in.wr & sel_row;
  wire wr_row2     = io_req_in.wr & sel_row2;
  wire wr_index    = io_req_in.wr & sel_index;
  wire wr_scratch  = io_req_in.wr & sel_scratch;

  wire [NUM_FLAGS-1:0] event_vec = {events_in.empty, events_in.overflow, events_in.busy, events_in.vsync};
  wire [NUM_FLAGS-1:0] clear_vec = wr_ctl ? io_req_in.wdata[CLEAR_LSB +: NUM_FLAGS] : '0;
  wire eng_rst_code_t  eng_code  = eng_rst_code_t'(io_req_in.wdata[ENG_RST_LSB +: 2]);

  // R6: clear on one, event wins over clear
  assign next_status = (status_flags & ~clear_vec) | event_vec;

  always_ff @(posedge clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      // R3: status resets to zero
      status_flags <= STATUS_RESET[NUM_FLAGS-1:0];
      irq_enables  <= CONTROL_RESET[ENABLE_LSB +: NUM_FLAGS];
      engine_held  <= 1'b0;
    end else begin
      status_flags <= next_status;
      if (wr_ctl) begin
        // R7: interrupt enables
        irq_enables <= io_req_in.wdata[ENABLE_LSB +: NUM_FLAGS];
        // R8: engine reset decode
        // R19: hold until enable code
        case (eng_code)
          ENG_ENABLE: engine_held <= 1'b0;
          ENG_RESET:  engine_held <= 1'b1;
          default:    engine_held <= engine_held;
        endcase
      end
    end
  end

  // R13: display function control, reserved bits stay zero
  always_ff @(posedge clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      disp_func <= DISP_FUNC_RESET;
    end else if (wr_disp) begin
      disp_func <= io_req_in.wdata & DISP_FUNC_MASK;
    end
  end

  // R14: host load or engine write-back of current row
  // R15: same start row serves blits and first polygon edge
  // R16: second edge row
  wire [11:0] next_row_start  = pick_row(wr_row, io_req_in.wdata, row_update_in, row_cur_in, row_start);
  wire [11:0] next_row_start2 = pick_row(wr_row2, io_req_in.wdata, row2_update_in, row2_cur_in, row_start2);

  // no reset: contents undefined until first load
  always_ff @(posedge clk_in) begin
    row_start  <= next_row_start;
    row_start2 <= next_row_start2;
  end

  always_ff @(posedge clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      crtc_index <= 8'h00;
    end else if (wr_index) begin
      crtc_index <= io_req_in.wdata[7:0];
    end
  end

  // R17: scratch byte
  scratch_store #(
    .WIDTH(8)
  ) u_scratch (
    .clk_in   (clk_in),
    .rstn_in  (rst_sync_n),
    .we_in    (wr_scratch),
    .wdata_in (io_req_in.wdata[7:0]),
    .rdata_out(scratch_q)
  );

  // R4: plane depth valid only for pixel field 00b
  wire plane_bit = ext_sys_depth_in & plane_8bit_in;
  // R5: read side of shared address is status
  // R2: reserved bits read zero
  wire [15:0] status_word = {8'h00, plane_bit, 3'b000, status_flags};

  // gated or unmapped reads fall through to zero
  wire [15:0] read_mux = sel_ctl     ? status_word :
                         sel_disp    ? disp_func :
                         sel_row     ? {4'h0, row_start} :
                         sel_row2    ? {4'h0, row_start2} :
                         sel_index   ? {8'h00, crtc_index} :
                         sel_scratch ? {8'h00, scratch_q} :
                                       16'h0000;

  always_ff @(posedge clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      io_rdata_out <= 16'h0000;
      irq_out      <= 1'b0;
    end else begin
      if (io_req_in.rd) begin
        io_rdata_out <= read_mux;
      end
      // R18: flagged and enabled
      irq_out <= |(next_status & irq_enables);
    end
  end

  assign engine_rstn_out   = ~engine_held;
  // R9: mode select
  assign enhanced_mode_out = disp_func[ENH_SELECT_BIT];
  // R10: pixel length
  assign pixel_4bit_out    = disp_func[ENH_PIXEL_BIT];
  // R11: linear OR
  assign linear_window_out = disp_func[LINEAR_BIT] | linear_ctl_in;
  // R12: mmio OR
  assign mmio_out          = disp_func[MMIO_BIT] | mem_ctl_in;
  assign row_start_out     = row_start;
  assign row_start2_out    = row_start2;

endmodule

// ===== dv/gecr_checker.sv
`timescale 1ns/10ps
module gecr_checker
  import gfx_regs_pkg::*;
(
  input wire logic        clk_in,            // clock
  input wire logic        rstn_in,           // reset, active low
  input wire io_req_t     io_req_in,         // host access
  input wire logic [15:0] io_rdata_out,      // read data
  input wire logic        sys_config_in,     // enhanced gate
  input wire logic        ext_sys_depth_in,  // pixel field 00b
  input wire logic        plane_8bit_in,     // eight planes
  input wire logic        linear_ctl_in,     // linear control bit
  input wire logic        mem_ctl_in,        // memory control bit
  input wire irq_events_t events_in,         // event pulses
  input wire logic        row_update_in,     // row write-back
  input wire logic        irq_out,           // interrupt
  input wire logic        engine_rstn_out,   // engine reset, low
  input wire logic        linear_window_out, // linear enable
  input wire logic        mmio_out,          // mmio enable
  input wire logic [11:0] row_start_out      // first row
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  wire        on = sys_config_in;
  wire        rd = io_req_in.rd;
  wire        wr = io_req_in.wr & on;
  wire [15:0] a  = io_req_in.addr;
  wire [15:0] d  = io_req_in.wdata;
  wire        sw = wr && a == SUBSYS_ADDR;
  wire        sr = rd && on && a == SUBSYS_ADDR;
  logic [11:0] d_q;
  always_ff @(posedge clk_in) d_q <= d[11:0];
  property p_lin; linear_ctl_in |-> linear_window_out; endproperty
  a_lin: assert property (p_lin) else $error("linear enable lost");
  property p_mmio; mem_ctl_in |-> mmio_out; endproperty
  a_mmio: assert property (p_mmio) else $error("mmio enable lost");
  property p_refuse; rd && !on && a == DISP_FUNC_ADDR |=> io_rdata_out == 16'h0000; endproperty
  a_refuse: assert property (p_refuse) else $error("gated read not zero");
  property p_stat; sr |=> io_rdata_out[15:8] == 8'h00 && io_rdata_out[6:4] == 3'h0; endproperty
  a_stat: assert property (p_stat) else $error("status spare bits set");
  property p_depth; sr && ext_sys_depth_in && plane_8bit_in |=> io_rdata_out[7]; endproperty
  a_depth: assert property (p_depth) else $error("depth bit low");
  property p_hold; !rd |=> $stable(io_rdata_out); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_grst; sw && d[15:14] == 2'b10 |=> !engine_rstn_out; endproperty
  a_grst: assert property (p_grst) else $error("engine not reset");
  property p_gen; sw && d[15:14] == 2'b01 |=> engine_rstn_out; endproperty
  a_gen: assert property (p_gen) else $error("engine not enabled");
  property p_ghold; !engine_rstn_out && !(sw && d[15:14] == 2'b01) |=> !engine_rstn_out; endproperty
  a_ghold: assert property (p_ghold) else $error("engine left reset");
  property p_clr; sw && d[3:0] == 4'hf && events_in == '0 |=> !irq_out; endproperty
  a_clr: assert property (p_clr) else $error("irq after clear");
  property p_row; wr && a == ROW_START_ADDR && !row_update_in |=> row_start_out == d_q; endproperty
  a_row: assert property (p_row) else $error("row not stored");
  c_rst: cover property (sw && d[15:14] == 2'b10);
  c_rd: cover property (sr);
  c_irq: cover property ($rose(irq_out));
endmodule

// ===== dv/tb.sv
`timescale 1ns/10ps
module tb
  import gfx_regs_pkg::*;
();
  logic        clk_in = 0, rstn_in = 0, cfg = 1, dep = 0, p8 = 0, lin = 0, mem = 0, ru = 0, ru2 = 0;
  io_req_t     req = '0;
  irq_events_t ev = '0;
  logic [11:0] rc = '0, rc2 = '0, r1, r2;
  logic [15:0] rdat;
  logic        irq, ern, enh, p4, lw, mm;
  int          miscompares = 0, checked = 0;
  logic [31:0] seed = 32'h00000039;
  always #50 clk_in = ~clk_in;
  graphics_engine_control_regs u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .io_req_in(req), .io_rdata_out(rdat),
    .sys_config_in(cfg), .ext_sys_depth_in(dep), .plane_8bit_in(p8), .linear_ctl_in(lin), .mem_ctl_in(mem),
    .events_in(ev), .row_update_in(ru), .row_cur_in(rc), .row2_update_in(ru2), .row2_cur_in(rc2),
    .irq_out(irq), .engine_rstn_out(ern), .enhanced_mode_out(enh), .pixel_4bit_out(p4),
    .linear_window_out(lw), .mmio_out(mm), .row_start_out(r1), .row_start2_out(r2));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic go(logic r, logic [15:0] a, logic [15:0] d);
    req = '{r, !r, a, d};
    @(negedge clk_in) req = '0;
    @(negedge clk_in);
  endtask
  task automatic rd(string n, logic [15:0] a, logic [15:0] e);
    go(1'b1, a, 16'h0000);
    chk(n, rdat, e);
  endtask
  task automatic end_sim();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #2000000;
    miscompares++;
    end_sim();
  end
  initial begin
    logic [15:0] d;
    logic [1:0]  c;
    logic        e;
    repeat (20) @(negedge clk_in);
    rstn_in = 1'b1;
    repeat (3) @(negedge clk_in);
    rd("status", SUBSYS_ADDR, STATUS_RESET);
    rd("dispfn", DISP_FUNC_ADDR, DISP_FUNC_RESET);
    go(1'b0, CRTC_INDEX_ADDR, {8'h00, SCRATCH_INDEX});
    rd("scratch", CRTC_DATA_ADDR, {8'h00, SCRATCH_RESET});
    chk("eng_rstn", 16'(ern), 16'h0001);
    $display("reset test done");
    cfg = 1'b0;
    go(1'b0, DISP_FUNC_ADDR, 16'h0035);
    rd("gated", DISP_FUNC_ADDR, 16'h0000);
    cfg = 1'b1;
    rd("dispfn", DISP_FUNC_ADDR, 16'h0000);
    $display("gate test done");
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 16'hffff : 16'(rnd());
      {mem, lin} = d[9:8];
      go(1'b0, DISP_FUNC_ADDR, d);
      rd("dispfn", DISP_FUNC_ADDR, d & DISP_FUNC_MASK);
      chk("modes", 16'({mm, lw, p4, enh}), 16'({d[5] | mem, d[4] | lin, d[2], d[0]}));
    end
    $display("mode test done");
    go(1'b0, SUBSYS_ADDR, 16'h0f00);
    ev = irq_events_t'(4'hf);
    @(negedge clk_in) ev = '0;
    for (int i = 0; i < 4; i++) begin
      go(1'b0, SUBSYS_ADDR, 16'h0f00 | (16'h0001 << i));
      rd("flags", SUBSYS_ADDR, 16'h000f & (16'h000f << (i + 1)));
      chk("irq", 16'(irq), 16'(i < 3));
    end
    go(1'b0, SUBSYS_ADDR, 16'h0000);
    ev = irq_events_t'(4'h1);
    @(negedge clk_in) ev = '0;
    rd("masked", SUBSYS_ADDR, 16'h0001);
    chk("irq", 16'(irq), 16'h0000);
    go(1'b0, SUBSYS_ADDR, 16'h000f);
    {dep, p8} = 2'b11;
    rd("depth", SUBSYS_ADDR, 16'h0080);
    p8 = 1'b0;
    rd("depth", SUBSYS_ADDR, 16'h0000);
    $display("irq test done");
    e = 1'b1;
    for (int i = 5; i >= 0; i--) begin
      c = 2'(12'h8d3 >> (2 * i));
      e = (c == ENG_RESET) ? 1'b0 : (c == ENG_ENABLE) ? 1'b1 : e;
      go(1'b0, SUBSYS_ADDR, {c, 14'h0000});
      chk("eng_rstn", 16'(ern), 16'(e));
    end
    $display("engine test done");
    for (int i = 0; i < 4; i++) begin
      d = 16'(rnd());
      go(1'b0, i[0] ? ROW_START2_ADDR : ROW_START_ADDR, d);
      chk("row", 16'(i[0] ? r2 : r1), 16'(d[11:0]));
      {rc, rc2} = 24'(rnd());
      {ru, ru2} = i[0] ? 2'b01 : 2'b10;
      @(negedge clk_in) {ru, ru2} = 2'b00;
      rd("rowcur", i[0] ? ROW_START2_ADDR : ROW_START_ADDR, 16'(i[0] ? rc2 : rc));
    end
    $display("row test done");
    d = 16'(rnd());
    go(1'b0, CRTC_DATA_ADDR, {8'h00, d[7:0]});
    rd("scratch", CRTC_DATA_ADDR, {8'h00, d[7:0]});
    rd("unmapped", 16'h1234, 16'h0000);
    $display("scratch test done");
    end_sim();
  end
endmodule
bind graphics_engine_control_regs gecr_checker u_chk (.clk_in, .rstn_in, .io_req_in, .io_rdata_out,
  .sys_config_in, .ext_sys_depth_in, .plane_8bit_in, .linear_ctl_in, .mem_ctl_in, .events_in,
  .row_update_in, .irq_out, .engine_rstn_out, .linear_window_out, .mmio_out, .row_start_out);
